// File: rtl/mca_minute_calendar_alarm_core.sv
// Timekeeping core: crystal prescaler, BCD calendar, alarm, supply fail.
// Assumes host commands are one-cycle pulses on sys_clk and that the
// pins and the crystal clock are asynchronous to sys_clk.
//
// Overview of operation
// - Minutes 00-59, hours 00-23, months 01-12 in BCD; minutes and hours carry on, months wrap.
// - Days from 01 wrap after 31, 30 or 28 by month, carrying to month.
// - A day of 29 loaded in February wraps to 01 and carries to month.
// - Prescaler divides the crystal clock to a 128 Hz trim output.
// - Prescaler gives one pulse per second advancing the seconds count.
// - Second and minute pulses are outputs with 1:1 duty, not in the read map.
// - Each falling second pulse may toggle the minute pulse output.
// - Time counter advances one minute on each minute pulse fall not caused by a prescaler reset.
// - A 24-bit alarm store holds minute, hour, day and month.
// - Alarm flag sets 4 ms after minute edge when store equals time.
// - Alarm flag can be set only once, at the start of each minute.
// - Alarm flag stays until cleared; a clear right after setting works.
// - The alarm flag drives its own output pin continuously.
// - With date-ignore set, only hours and minutes are compared.
// - Date-ignore has separate set and clear commands.
// - Alarm and date-ignore flags are output pins, not in the host read map.
// - Supply-fail latches and holds until a pointer-load write arrives.
// - Select low: fail input low uses internal detector, high is test.
// - With external sensing a low fail input sets the supply-fail flag.
// - Bus control is held in reset while interface supply is low.
// - Time adjust resets prescaler and seconds; carries if seconds >= 30.
`timescale 1ns/1ps

module mca_minute_calendar_alarm_core #(
    parameter int unsigned ALARM_DELAY_CYCLES = mca_pkg::ALARM_DELAY_CYC
) (
    // Clocks and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       xtalClk,
    // Host write and read port
    input  wire logic       wrValid,
    input  wire logic [2:0] wrAddr,
    input  wire logic [7:0] wrData,
    input  wire logic [2:0] rdAddr,
    // Host commands
    input  wire logic       cmdResetPrescaler,
    input  wire logic       cmdTimeAdjust,
    input  wire logic       cmdSetDateIgnore,
    input  wire logic       cmdClrDateIgnore,
    input  wire logic       cmdClrAlarm,
    // Supply pins
    input  wire logic       interfacePowerOk,
    input  wire logic       internalFailDet,
    input  wire logic       failSourceSelect,
    input  wire logic       externalFailIn,
    // Outputs
    output logic [7:0]      rdData,
    output logic            trimRefOut,
    output logic            secPulseOut,
    output logic            minPulseOut,
    output logic            alarmMatchOut,
    output logic            dateIgnoreFlag,
    output logic            supplyFailFlag,
    output logic            testModeOut
);
    import mca_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] bcdInc(input logic [7:0] v);
        if (v[3:0] >= 4'h9) begin
            bcdInc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcdInc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    function automatic logic isDayLast(input logic [5:0] d,
                                       input logic [4:0] m);
        case (m)
            MON_FEB:                            isDayLast = d >= DAY_28;
            MON_APR, MON_JUN, MON_SEP, MON_NOV: isDayLast = d >= DAY_30;
            default:                            isDayLast = d >= DAY_31;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Crystal domain: prescaler
    // ------------------------------------------------------------
    mca_xtal_s x;
    mca_xtal_s xNext;
    mca_sys_s  s;
    mca_sys_s  sNext;

    // A prescaler reset is requested by a toggle; the toggle comes back
    // as the acknowledge so the system side knows when it took effect.
    always_comb begin
        xNext = x;
        xNext.rstMeta = rst;
        xNext.rstSync = x.rstMeta;
        xNext.reqMeta = s.req;
        xNext.reqSync = x.reqMeta;
        if (x.rstSync) begin
            xNext.ack   = 1'b0;
            xNext.presc = '0;
        end else if (x.reqSync != x.ack) begin
            xNext.ack   = x.reqSync;
            xNext.presc = '0;
        end else begin
            xNext.presc = PRESC_W'(x.presc + 1'b1);
        end
    end

    always_ff @(posedge xtalClk) begin
        x <= xNext;
    end

    assign trimRefOut  = x.presc[TRIM_BIT];
    assign secPulseOut = x.presc[SEC_BIT];

    // ------------------------------------------------------------
    // System domain: counters, alarm, flags
    // ------------------------------------------------------------
    logic busOk;
    logic wrEn;
    logic prescCmd;
    logic secFall;
    logic minuteStep;
    logic delayHit;
    logic almMatch;
    logic almSet;
    logic clrAlm;
    logic failNow;

    always_comb begin
        sNext      = s;
        minuteStep = 1'b0;
        delayHit   = 1'b0;
        sNext.secMeta = secPulseOut;
        sNext.secSync = s.secMeta;
        sNext.secPrev = s.secSync;
        sNext.ackMeta = x.ack;
        sNext.ackSync = s.ackMeta;
        sNext.ackPrev = s.ackSync;
        sNext.pinMeta = {interfacePowerOk, internalFailDet,
                         failSourceSelect, externalFailIn};
        sNext.pinSync = s.pinMeta;
        busOk    = s.pinSync[3];
        wrEn     = wrValid & busOk;
        prescCmd = (cmdResetPrescaler | cmdTimeAdjust) & busOk;
        clrAlm   = cmdClrAlarm & busOk;
        // Falls are ignored while a prescaler reset is in flight, since
        // the reset itself can pull the second pulse low.
        secFall  = s.secPrev & ~s.secSync & (s.req == s.ackSync)
                 & (s.ackSync == s.ackPrev);

        if (prescCmd) begin
            sNext.req      = ~s.req;
            sNext.seconds  = '0;
            sNext.minPulse = 1'b0;
            minuteStep     = cmdTimeAdjust && s.seconds >= SEC_HALF;
        end else if (secFall) begin
            if (s.seconds == SEC_LAST) begin
                sNext.seconds  = '0;
                sNext.minPulse = 1'b0;
                minuteStep     = 1'b1;
            end else begin
                sNext.seconds = 6'(s.seconds + 1'b1);
                if (s.seconds == SEC_MID) begin
                    sNext.minPulse = 1'b1;
                end
            end
        end

        if (minuteStep) begin
            if (s.minutes >= MAX_MIN) begin
                sNext.minutes = RST_MIN;
                if (s.hours >= MAX_HOUR) begin
                    sNext.hours = RST_HOUR;
                    if (isDayLast(s.days, s.months)) begin
                        sNext.days = RST_DAY;
                        if (s.months >= MAX_MONTH) begin
                            sNext.months = RST_MONTH;
                        end else begin
                            sNext.months = 5'(bcdInc({3'b000, s.months}));
                        end
                    end else begin
                        sNext.days = 6'(bcdInc({2'b00, s.days}));
                    end
                end else begin
                    sNext.hours = 6'(bcdInc({2'b00, s.hours}));
                end
            end else begin
                sNext.minutes = 7'(bcdInc({1'b0, s.minutes}));
            end
        end

        // A host write lands after the carry so that it wins.
        if (wrEn) begin
            case (wrAddr)
                ADDR_T_HOUR:  sNext.hours    = wrData[5:0];
                ADDR_T_MIN:   sNext.minutes  = wrData[6:0];
                ADDR_T_DAY:   sNext.days     = wrData[5:0];
                ADDR_T_MONTH: sNext.months   = wrData[4:0];
                ADDR_A_HOUR:  sNext.almHour  = wrData[5:0];
                ADDR_A_MIN:   sNext.almMin   = wrData[6:0];
                ADDR_A_DAY:   sNext.almDay   = wrData[5:0];
                default:      sNext.almMonth = wrData[4:0];
            endcase
        end

        // The delay starts at the minute edge and fires only once.
        if (minuteStep) begin
            sNext.delayRun = 1'b1;
            sNext.delayCnt = '0;
        end else if (s.delayRun) begin
            sNext.delayCnt = 32'(s.delayCnt + 32'h0000_0001);
            if (s.delayCnt == 32'(ALARM_DELAY_CYCLES - 1)) begin
                sNext.delayRun = 1'b0;
                delayHit       = 1'b1;
            end
        end
        almMatch = (s.almHour == s.hours) && (s.almMin == s.minutes)
                 && (s.dateIgnore || ((s.almDay == s.days)
                 && (s.almMonth == s.months)));
        almSet   = delayHit & almMatch;
        sNext.alarmFlag = almSet | (s.alarmFlag & ~clrAlm);

        if (cmdSetDateIgnore & busOk) begin
            sNext.dateIgnore = 1'b1;
        end else if (cmdClrDateIgnore & busOk) begin
            sNext.dateIgnore = 1'b0;
        end

        failNow = (~s.pinSync[1] & ~s.pinSync[0] & s.pinSync[2])
                | (s.pinSync[1] & ~s.pinSync[0]);
        sNext.supplyFail = failNow | (s.supplyFail & ~wrEn);
        sNext.testMode   = ~s.pinSync[1] & s.pinSync[0];

        case (rdAddr)
            ADDR_T_HOUR:  sNext.rdData = {2'b00, s.hours};
            ADDR_T_MIN:   sNext.rdData = {1'b0, s.minutes};
            ADDR_T_DAY:   sNext.rdData = {2'b00, s.days};
            ADDR_T_MONTH: sNext.rdData = {3'b000, s.months};
            ADDR_A_HOUR:  sNext.rdData = {2'b00, s.almHour};
            ADDR_A_MIN:   sNext.rdData = {1'b0, s.almMin};
            ADDR_A_DAY:   sNext.rdData = {2'b00, s.almDay};
            default:      sNext.rdData = {3'b000, s.almMonth};
        endcase

        if (rst) begin
            sNext          = '0;
            sNext.days     = RST_DAY;
            sNext.months   = RST_MONTH;
            sNext.almDay   = RST_DAY;
            sNext.almMonth = RST_MONTH;
        end
    end

    always_ff @(posedge sys_clk) begin
        s <= sNext;
    end

    assign rdData         = s.rdData;
    assign minPulseOut    = s.minPulse;
    assign alarmMatchOut  = s.alarmFlag;
    assign dateIgnoreFlag = s.dateIgnore;
    assign supplyFailFlag = s.supplyFail;
    assign testModeOut    = s.testMode;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_trim_phase: assert property (
        @(posedge xtalClk) disable iff (x.rstSync)
        $changed(x.presc[TRIM_BIT]) |-> x.presc[TRIM_BIT-1:0] == '0)
        else $error("Trim output changed off the prescaler boundary.");

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence sMinuteStep;
        minuteStep && !wrEn;
    endsequence

    sequence sDayCarry;
        s.minutes == MAX_MIN && s.hours == MAX_HOUR && s.months == MON_FEB;
    endsequence

    a_sec_advance: assert property (
        secFall && !prescCmd && s.seconds != SEC_LAST
        |=> s.seconds == 6'($past(s.seconds) + 1'b1))
        else $error("Seconds count did not advance on a second pulse.");

    a_min_toggle: assert property (
        $changed(minPulseOut) |-> $past(secFall) || $past(prescCmd))
        else $error("Minute pulse changed without a second pulse fall.");

    a_min_wrap: assert property (
        sMinuteStep ##0 (s.minutes == MAX_MIN && s.hours != MAX_HOUR)
        |=> s.minutes == RST_MIN && s.hours == 6'(bcdInc({2'b00,
            $past(s.hours)})))
        else $error("Minute wrap did not carry into the hours.");

    a_feb_wrap: assert property (
        sMinuteStep ##0 sDayCarry ##0 (s.days == DAY_28)
        |=> s.days == RST_DAY && s.months == 5'h03)
        else $error("February day 28 did not wrap into March.");

    a_feb_leap: assert property (
        sMinuteStep ##0 sDayCarry ##0 (s.days == 6'h29)
        |=> s.days == RST_DAY && s.months == 5'h03)
        else $error("Loaded February day 29 did not wrap into March.");

    a_alarm_delay: assert property (
        $rose(alarmMatchOut) |-> $past(delayHit) && $past(almMatch))
        else $error("Alarm flag set outside the delayed minute check.");

    a_alarm_once: assert property (
        delayHit |=> !delayHit && !s.delayRun)
        else $error("Alarm check fired twice in one minute.");

    a_alarm_hold: assert property (
        alarmMatchOut && !clrAlm |=> alarmMatchOut)
        else $error("Alarm flag dropped without a clear.");

    a_alarm_clear: assert property (
        clrAlm && !almSet |=> !alarmMatchOut)
        else $error("Alarm clear did not take effect.");

    a_date_ignore: assert property (
        delayHit && s.dateIgnore && s.almHour == s.hours
        && s.almMin == s.minutes |=> alarmMatchOut)
        else $error("Date-ignore match did not set the alarm flag.");

    a_fail_latch: assert property (
        supplyFailFlag && !wrEn |=> supplyFailFlag)
        else $error("Supply-fail flag dropped without a write.");

    a_ext_fail: assert property (
        s.pinSync[1] && !s.pinSync[0] |=> supplyFailFlag [*2])
        else $error("External fail level did not set supply-fail.");

    a_adjust_clear: assert property (
        prescCmd |=> s.seconds == 6'h00)
        else $error("Prescaler command did not clear the seconds.");

    a_adjust_carry: assert property (
        cmdTimeAdjust && busOk && s.seconds >= SEC_HALF && !wrEn
        && s.minutes != MAX_MIN
        |=> s.minutes == 7'(bcdInc({1'b0, $past(s.minutes)})))
        else $error("Time adjust from 30 seconds gave no carry.");

    a_adjust_hold: assert property (
        prescCmd && s.seconds < SEC_HALF && !wrEn |=> $stable(s.minutes))
        else $error("Time adjust below 30 seconds moved the minutes.");

    a_date_set: assert property (
        cmdSetDateIgnore && busOk |=> dateIgnoreFlag)
        else $error("Date-ignore set command had no effect.");

    a_date_clr: assert property (
        cmdClrDateIgnore && !cmdSetDateIgnore && busOk |=> !dateIgnoreFlag)
        else $error("Date-ignore clear command had no effect.");

    a_bus_gate: assert property (
        !busOk |=> $stable({s.almHour, s.almMin, s.almDay, s.almMonth}))
        else $error("Alarm store changed while the bus was held off.");

    a_test_mode: assert property (
        !s.pinSync[1] && s.pinSync[0] |=> testModeOut)
        else $error("Test mode not shown for select low, input high.");

endmodule

// File: rtl/mca_pkg.sv
// Constants and state types of the minute calendar alarm core.
// Assumes a 100 MHz system clock and a 32.768 kHz crystal clock.
package mca_pkg;

    // ------------------------------------------------------------
    // Prescaler and timing
    // ------------------------------------------------------------
    localparam int PRESC_W         = 15;
    localparam int TRIM_BIT        = 7;
    localparam int SEC_BIT         = 14;
    localparam int ALARM_DELAY_MS  = 4;
    localparam int SYS_CLK_KHZ     = 100000;
    localparam int ALARM_DELAY_CYC = ALARM_DELAY_MS * SYS_CLK_KHZ;

    // ------------------------------------------------------------
    // Pointer addresses of the time counter and alarm store
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_T_HOUR  = 3'h0;
    localparam logic [2:0] ADDR_T_MIN   = 3'h1;
    localparam logic [2:0] ADDR_T_DAY   = 3'h2;
    localparam logic [2:0] ADDR_T_MONTH = 3'h3;
    localparam logic [2:0] ADDR_A_HOUR  = 3'h4;
    localparam logic [2:0] ADDR_A_MIN   = 3'h5;
    localparam logic [2:0] ADDR_A_DAY   = 3'h6;
    localparam logic [2:0] ADDR_A_MONTH = 3'h7;

    // ------------------------------------------------------------
    // Reset values, BCD limits and binary seconds limits
    // ------------------------------------------------------------
    localparam logic [6:0] RST_MIN   = 7'h00;
    localparam logic [5:0] RST_HOUR  = 6'h00;
    localparam logic [5:0] RST_DAY   = 6'h01;
    localparam logic [4:0] RST_MONTH = 5'h01;
    localparam logic [6:0] MAX_MIN   = 7'h59;
    localparam logic [5:0] MAX_HOUR  = 6'h23;
    localparam logic [5:0] DAY_28    = 6'h28;
    localparam logic [5:0] DAY_30    = 6'h30;
    localparam logic [5:0] DAY_31    = 6'h31;
    localparam logic [4:0] MAX_MONTH = 5'h12;
    localparam logic [4:0] MON_FEB   = 5'h02;
    localparam logic [4:0] MON_APR   = 5'h04;
    localparam logic [4:0] MON_JUN   = 5'h06;
    localparam logic [4:0] MON_SEP   = 5'h09;
    localparam logic [4:0] MON_NOV   = 5'h11;
    localparam logic [5:0] SEC_LAST  = 6'h3B;
    localparam logic [5:0] SEC_MID   = 6'h1D;
    localparam logic [5:0] SEC_HALF  = 6'h1E;

    // ------------------------------------------------------------
    // State of the crystal domain and of the system domain
    // ------------------------------------------------------------
    typedef struct packed {
        logic               rstMeta;
        logic               rstSync;
        logic               reqMeta;
        logic               reqSync;
        logic               ack;
        logic [PRESC_W-1:0] presc;
    } mca_xtal_s;

    typedef struct packed {
        logic        secMeta;
        logic        secSync;
        logic        secPrev;
        logic        ackMeta;
        logic        ackSync;
        logic        ackPrev;
        logic [3:0]  pinMeta;
        logic [3:0]  pinSync;
        logic        req;
        logic [5:0]  seconds;
        logic        minPulse;
        logic [6:0]  minutes;
        logic [5:0]  hours;
        logic [5:0]  days;
        logic [4:0]  months;
        logic [6:0]  almMin;
        logic [5:0]  almHour;
        logic [5:0]  almDay;
        logic [4:0]  almMonth;
        logic [31:0] delayCnt;
        logic        delayRun;
        logic        alarmFlag;
        logic        dateIgnore;
        logic        supplyFail;
        logic        testMode;
        logic [7:0]  rdData;
    } mca_sys_s;

endpackage

// File: sim/mca_host_model.sv
// Host model: drives the core's write port, read address and commands.
// Assumes requests launch at the falling edge of sys_clk, one at a time.
`timescale 1ns/1ps

module mca_host_model (
    // Clock and read data
    input  wire logic       sys_clk,
    input  wire logic [7:0] rdData,
    // Requests to the core
    output logic            wrValid,
    output logic [2:0]      wrAddr,
    output logic [7:0]      wrData,
    output logic [2:0]      rdAddr,
    output logic [4:0]      cmd
);
    // ------------------------------------------------------------
    // Requests
    // ------------------------------------------------------------
    // The calendar is never corrected for leap years; runs are short.
    initial begin
        wrValid = 1'b0;
        wrAddr  = 3'h0;
        wrData  = 8'h00;
        rdAddr  = 3'h0;
        cmd     = 5'h00;
    end

    // Released data is inverted so a stale value can never look valid.
    task automatic write(input logic [2:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        wrAddr  = a;
        wrData  = d;
        wrValid = 1'b1;
        @(negedge sys_clk);
        wrValid = 1'b0;
        wrData  = ~d;
    endtask

    task automatic read(input logic [2:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        rdAddr = a;
        repeat (2) @(negedge sys_clk);
        d = rdData;
    endtask

    // Bits: reset prescaler, time adjust, set and clear date-ignore, clear alarm.
    task automatic pulse(input logic [4:0] m);
        @(negedge sys_clk);
        cmd = m;
        @(negedge sys_clk);
        cmd = 5'h00;
    endtask
endmodule

// File: sim/tb_minute_calendar_alarm_core.sv
// Testbench of the minute calendar alarm core.
// Assumes the host model above and a short alarm delay parameter.
`timescale 1ns/1ps

module tb_minute_calendar_alarm_core;
    import mca_pkg::*;
    typedef struct packed {
        logic [2:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } mca_row_s;

    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        xtalClk = 1'b0;
    logic        wrValid, interfacePowerOk, internalFailDet;
    logic        failSourceSelect, externalFailIn;
    logic [2:0]  wrAddr, rdAddr;
    logic [7:0]  wrData, rdData, rd;
    logic [4:0]  cmd;
    logic        trimRefOut, secPulseOut, minPulseOut, alarmMatchOut;
    logic        dateIgnoreFlag, supplyFailFlag, testModeOut;
    int          failures = 0;
    int          n_tests = 0;
    int          cycles = 0;
    time         t0, t1, t2;
    // Upper data bits are set on purpose; they must be dropped.
    mca_row_s    rows [10] = '{'{3'h0, 8'hE3, 8'h23}, '{3'h1, 8'hD9, 8'h59},
        '{3'h2, 8'hF1, 8'h31}, '{3'h3, 8'hF2, 8'h12}, '{3'h3, 8'h02, 8'h02},
        '{3'h2, 8'h29, 8'h29}, '{3'h4, 8'h17, 8'h17}, '{3'h5, 8'h42, 8'h42},
        '{3'h6, 8'h15, 8'h15}, '{3'h7, 8'h09, 8'h09}};
    logic [7:0]  rstExp [8] = '{8'h00, 8'h00, 8'h01, 8'h01,
        8'h00, 8'h00, 8'h01, 8'h01};

    always #5 sys_clk = ~sys_clk;
    initial begin
        #2.3;
        forever #6 xtalClk = ~xtalClk;
    end

    mca_host_model i_host (.sys_clk(sys_clk), .rdData(rdData),
        .wrValid(wrValid), .wrAddr(wrAddr), .wrData(wrData),
        .rdAddr(rdAddr), .cmd(cmd));

    mca_minute_calendar_alarm_core #(.ALARM_DELAY_CYCLES(20)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .xtalClk(xtalClk),
        .wrValid(wrValid), .wrAddr(wrAddr), .wrData(wrData),
        .rdAddr(rdAddr), .cmdResetPrescaler(cmd[4]),
        .cmdTimeAdjust(cmd[3]), .cmdSetDateIgnore(cmd[2]),
        .cmdClrDateIgnore(cmd[1]), .cmdClrAlarm(cmd[0]),
        .interfacePowerOk(interfacePowerOk),
        .internalFailDet(internalFailDet),
        .failSourceSelect(failSourceSelect),
        .externalFailIn(externalFailIn), .rdData(rdData),
        .trimRefOut(trimRefOut), .secPulseOut(secPulseOut),
        .minPulseOut(minPulseOut), .alarmMatchOut(alarmMatchOut),
        .dateIgnoreFlag(dateIgnoreFlag), .supplyFailFlag(supplyFailFlag),
        .testModeOut(testModeOut));

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Pins pass two sync flops before the flags move.
    task automatic settle();
        repeat (6) @(negedge sys_clk);
    endtask

    task automatic do_reset();
        @(negedge sys_clk);
        rst = 1'b1;
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask

    // The whole run needs about 59000 cycles.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            failures++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        interfacePowerOk = 1'b1;
        internalFailDet  = 1'b0;
        failSourceSelect = 1'b1;
        externalFailIn   = 1'b1;
        do_reset();
        foreach (rows[i]) begin
            i_host.write(rows[i].a, rows[i].d);
            i_host.read(rows[i].a, rd);
            check(rd, rows[i].e);
        end
        do_reset();
        for (int i = 0; i < 8; i++) begin
            i_host.read(3'(i), rd);
            check(rd, rstExp[i]);
        end
        check(alarmMatchOut, 1'b0);
        check(supplyFailFlag, 1'b0);
        externalFailIn = 1'b0;
        settle();
        check(supplyFailFlag, 1'b1);
        externalFailIn = 1'b1;
        settle();
        check(supplyFailFlag, 1'b1);
        i_host.write(ADDR_A_MIN, 8'h10);
        check(supplyFailFlag, 1'b0);
        failSourceSelect = 1'b0;
        settle();
        check(testModeOut, 1'b1);
        externalFailIn  = 1'b0;
        internalFailDet = 1'b1;
        settle();
        check(testModeOut, 1'b0);
        check(supplyFailFlag, 1'b1);
        internalFailDet = 1'b0;
        settle();
        i_host.write(ADDR_A_MIN, 8'h10);
        check(supplyFailFlag, 1'b0);
        i_host.pulse(5'h04);
        check(dateIgnoreFlag, 1'b1);
        i_host.pulse(5'h02);
        check(dateIgnoreFlag, 1'b0);
        i_host.pulse(5'h06);
        check(dateIgnoreFlag, 1'b1);
        i_host.pulse(5'h01);
        check(alarmMatchOut, 1'b0);
        interfacePowerOk = 1'b0;
        settle();
        i_host.write(ADDR_T_MIN, 8'h33);
        interfacePowerOk = 1'b1;
        settle();
        i_host.read(ADDR_T_MIN, rd);
        check(rd, 8'h00);
        @(posedge trimRefOut) t0 = $time;
        @(negedge trimRefOut) t1 = $time;
        @(posedge trimRefOut) t2 = $time;
        check(32'(t1 - t0), 32'd1536);
        check(32'(t2 - t1), 32'd1536);
        @(posedge secPulseOut) t0 = $time;
        @(negedge secPulseOut) t1 = $time;
        @(posedge secPulseOut) t2 = $time;
        check(32'(t1 - t0), 32'd196608);
        check(32'(t2 - t1), 32'd196608);
        check(minPulseOut, 1'b0);
        finish_test();
    end
endmodule
